//--- far_side_model.sv
// far side of timer 2: trigger pin driver, count pin wire, serial tick sink
// assumes the bench sets trigger_level_i just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        trigger_level_i,
   input  wire logic        count_level_i,
   input  wire logic        overflow_tick_i,
   input  wire logic        count_out_i,
   input  wire logic        count_oe_n_i,
   input  wire logic        count_pullup_i,
   output logic             trigger_pin_o,
   output logic             count_pin_o,
   output logic [15:0]      tick_count_o,
   output logic [15:0]      toggle_count_o
);
   logic alt;
   logic last_pin;

   ////////////////////////////////////////////////////////////////////////////
   // released pin: outside source over the pull-up, else never settles
   assign count_pin_o = !count_oe_n_i ? count_out_i :
                        (count_pullup_i ? count_level_i : alt);

   // trigger held at least one full cycle per level, idles high
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trigger_pin_o  <= 1'b1;
         alt            <= 1'b0;
         last_pin       <= 1'b0;
         tick_count_o   <= 16'h0000;
         toggle_count_o <= 16'h0000;
      end else begin
         trigger_pin_o <= trigger_level_i;
         alt           <= ~alt;
         last_pin      <= count_pin_o;
         // serial port consumes one overflow per tick
         if (overflow_tick_i) begin
            tick_count_o <= tick_count_o + 16'h0001;
         end
         // clock-out edges only count while the block drives the pin
         if (!count_oe_n_i && count_pin_o != last_pin) begin
            toggle_count_o <= toggle_count_o + 16'h0001;
         end
      end
   end
endmodule // far_side_model

`default_nettype wire

//--- tb_top.sv
// bench for timer 2: wishbone register tasks and table-driven scenarios
// assumes the far side model supplies pins and counts serial ticks
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import timer2_pkg::*;
;
   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  ctl_x;
      logic [15:0] rl_x;
      logic [15:0] cnt_x;
   } trig_case_s;

   logic        ref_clk_i, rst_i, wb_cyc, wb_stb, wb_we, trig_level;
   logic        count_level;
   logic [11:0] wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic        wb_ack_o, count_pin, count_pin_o, count_pin_oe_n_o;
   logic        count_pullup_o, trigger_pin, overflow_tick_o;
   logic        rx_baud_select_o, tx_baud_select_o, timer_irq_o;
   logic [15:0] ticks, toggles, t0, g0;
   logic [7:0]  v;
   int          errors, total_checks, i;
   logic [9:0]  map [6] = '{IDX_CONTROL, IDX_MODE, IDX_RELOAD_LO,
                            IDX_RELOAD_HI, IDX_COUNT_LO, IDX_COUNT_HI};
   trig_case_s  tc [5] = '{'{8'h08, 8'h48, 16'hfff0, 16'hfff0},
                           '{8'h09, 8'h49, 16'h1234, 16'h1234},
                           '{8'h01, 8'h01, 16'hfff0, 16'h1234},
                           '{8'h18, 8'h58, 16'hfff0, 16'h1234},
                           '{8'h28, 8'h68, 16'hfff0, 16'h1234}};

   ////////////////////////////////////////////////////////////////////////////
   timer2_capture_reload_baud dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .count_pin_i(count_pin),
      .count_pin_o(count_pin_o), .count_pin_oe_n_o(count_pin_oe_n_o),
      .count_pullup_o(count_pullup_o), .trigger_pin_i(trigger_pin),
      .overflow_tick_o(overflow_tick_o),
      .rx_baud_select_o(rx_baud_select_o),
      .tx_baud_select_o(tx_baud_select_o), .timer_irq_o(timer_irq_o));

   far_side_model far (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .trigger_level_i(trig_level),
      .overflow_tick_i(overflow_tick_o), .count_out_i(count_pin_o),
      .count_level_i(count_level),
      .count_oe_n_i(count_pin_oe_n_o), .count_pullup_i(count_pullup_o),
      .trigger_pin_o(trigger_pin), .count_pin_o(count_pin),
      .tick_count_o(ticks), .toggle_count_o(toggles));

   // 100 MHz system clock
   always #5 ref_clk_i = ~ref_clk_i;

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one classic cycle; the bound stands in for a hung slave
   task automatic xfer(input logic [9:0] idx, input logic we,
                       input logic [7:0] wd);
      int n;
      @(posedge ref_clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h000000, wd};
      wb_sel <= 4'hf;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      v = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50) begin
         errors++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask

   task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
      xfer(idx, 1'b0, 8'h00);
      chk({8'h00, v}, {8'h00, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // polls the control register until a flag shows up
   task automatic wait_flag(input logic [7:0] mask);
      int n;
      v = 8'h00;
      n = 0;
      while ((v & mask) == 8'h00 && n < 60) begin
         xfer(IDX_CONTROL, 1'b0, 8'h00);
         n++;
      end
      if (n >= 60) begin
         errors++;
         stop_test();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
      trig_level = 1'b1;
      count_level = 1'b1;
      errors = 0;
      total_checks = 0;
      idle(8);
      rst_i <= 1'b0;
      for (i = 0; i < 6; i++) rdchk(map[i], 8'h00);
      chk({15'h0000, count_pin_oe_n_o}, 16'h0001);
      wr(10'h0e0, 8'hff);
      rdchk(10'h0e0, 8'h00);
      // stopped timer keeps what software wrote
      for (i = 2; i < 6; i++) wr(map[i], 8'h50 + 8'(i));
      idle(20);
      for (i = 2; i < 6; i++) rdchk(map[i], 8'h50 + 8'(i));
      // trigger edges in reload, capture and baud set-ups, timer stopped so results are exact
      for (i = 0; i < 5; i++) begin
         wr(IDX_CONTROL, 8'h00);
         wr(IDX_RELOAD_LO, 8'hf0);
         wr(IDX_RELOAD_HI, 8'hff);
         wr(IDX_COUNT_LO, 8'h34);
         wr(IDX_COUNT_HI, 8'h12);
         wr(IDX_CONTROL, tc[i].ctl);
         trig_level <= 1'b0;
         idle(6);
         trig_level <= 1'b1;
         idle(6);
         rdchk(IDX_CONTROL, tc[i].ctl_x);
         rdchk(IDX_RELOAD_HI, tc[i].rl_x[15:8]);
         rdchk(IDX_RELOAD_LO, tc[i].rl_x[7:0]);
         rdchk(IDX_COUNT_HI, tc[i].cnt_x[15:8]);
         rdchk(IDX_COUNT_LO, tc[i].cnt_x[7:0]);
         chk({14'h0000, rx_baud_select_o, tx_baud_select_o},
             {14'h0000, tc[i].ctl[5:4]});
      end
      // up/down: count down into the reload value, then up past 0xffff
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_MODE, 8'h01);
      wr(IDX_RELOAD_LO, 8'h00);
      wr(IDX_RELOAD_HI, 8'h10);
      wr(IDX_COUNT_LO, 8'h02);
      wr(IDX_COUNT_HI, 8'h10);
      trig_level <= 1'b0;
      wr(IDX_CONTROL, 8'h04);
      wait_flag(8'h80);
      chk({8'h00, v}, 16'h00c4);
      wr(IDX_CONTROL, 8'hc0);
      rdchk(IDX_COUNT_HI, 8'hff);
      trig_level <= 1'b1;
      wr(IDX_COUNT_LO, 8'hfe);
      wr(IDX_COUNT_HI, 8'hff);
      wr(IDX_CONTROL, 8'h04);
      wait_flag(8'h80);
      chk({8'h00, v}, 16'h00c4);
      wr(IDX_CONTROL, 8'hc0);
      rdchk(IDX_COUNT_HI, 8'h10);
      // baud ticks and clock output together: one overflow per 8 clocks
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_MODE, 8'h02);
      wr(IDX_RELOAD_LO, 8'hfc);
      wr(IDX_RELOAD_HI, 8'hff);
      wr(IDX_COUNT_LO, 8'hfc);
      wr(IDX_COUNT_HI, 8'hff);
      wr(IDX_CONTROL, 8'h14);
      chk({15'h0000, count_pin_oe_n_o}, 16'h0000);
      idle(8);
      t0 = ticks;
      g0 = toggles;
      idle(160);
      chk(ticks - t0, 16'h0014);
      chk(toggles - g0, 16'h0014);
      rdchk(IDX_CONTROL, 8'h14);
      wr(IDX_CONTROL, 8'h10);
      idle(4);
      t0 = ticks;
      idle(40);
      chk(ticks - t0, 16'h0000);
      // counter mode on a pin held high by the pull-up never advances
      wr(IDX_MODE, 8'h00);
      wr(IDX_COUNT_LO, 8'h00);
      wr(IDX_CONTROL, 8'h02);
      idle(4);
      wr(IDX_CONTROL, 8'h06);
      chk({15'h0000, count_pullup_o}, 16'h0001);
      idle(30);
      wr(IDX_CONTROL, 8'h02);
      rdchk(IDX_COUNT_LO, 8'h00);
      // five falling edges from outside, each level held three clocks
      wr(IDX_CONTROL, 8'h06);
      for (i = 0; i < 5; i++) begin
         count_level <= 1'b0;
         idle(3);
         count_level <= 1'b1;
         idle(3);
      end
      wr(IDX_CONTROL, 8'h02);
      rdchk(IDX_COUNT_LO, 8'h05);
      // up-only reload mode: overflow flags and reloads from the register
      wr(IDX_RELOAD_HI, 8'h80);
      wr(IDX_COUNT_LO, 8'hf0);
      wr(IDX_COUNT_HI, 8'hff);
      wr(IDX_CONTROL, 8'h04);
      wait_flag(8'h80);
      chk({8'h00, v}, 16'h0084);
      wr(IDX_CONTROL, 8'h80);
      rdchk(IDX_COUNT_HI, 8'h80);
      // flags set by software raise the request unless masked; in up/down the event flag raises none
      wr(IDX_IRQ_ENABLE, 8'h03);
      wr(IDX_CONTROL, 8'h80);
      idle(3);
      chk({15'h0000, timer_irq_o}, 16'h0001);
      rdchk(IDX_CONTROL, 8'h80);
      wr(IDX_IRQ_ENABLE, 8'h01);
      idle(3);
      chk({15'h0000, timer_irq_o}, 16'h0000);
      wr(IDX_IRQ_ENABLE, 8'h03);
      wr(IDX_CONTROL, 8'h40);
      idle(3);
      chk({15'h0000, timer_irq_o}, 16'h0001);
      wr(IDX_MODE, 8'h01);
      idle(3);
      chk({15'h0000, timer_irq_o}, 16'h0000);
      wr(IDX_CONTROL, 8'h00);
      idle(3);
      chk({15'h0000, timer_irq_o}, 16'h0000);
      stop_test();
   end
endmodule // tb_top

`default_nettype wire

//--- timer2_capture_reload_baud.sv
// timer 2: 16-bit capture / auto-reload / up-down / baud and clock generator
// assumes a classic wishbone master on ref_clk_i; pins are asynchronous
//
// How it works
// RQ1: overflow flag set by overflow only when no baud select bit is set.
// RQ2: external event flag set on trigger falling edge when trigger enabled.
// RQ3: control bits 5 and 4 pick receive and transmit baud sources.
// RQ4: trigger edge captures or reloads if enabled and not clocking serial port.
// RQ5: timer counts only while the run bit is one, in every mode.
// RQ6: count source bit picks system clock or count pin, with pull-up.
// RQ7: control bit 0 picks reload (0) or capture (1).
// RQ8: mode bit 1 drives the count pin as a clock output.
// RQ9: mode bit 0 clear counts up only; set gives up/down auto-reload.
// RQ10: mode decoded from control bits; baud select overrides capture select.
// RQ11: capture mode flags overflow and copies count on trigger edges.
// RQ12: up auto-reload reloads at 0xffff overflow or on enabled trigger edge.
// RQ13: up/down counts up while trigger pin high, reloading on overflow.
// RQ14: up/down counts down while trigger low, loading 0xffff at reload value.
// RQ15: up/down toggles the event flag on each wrap, as a 17th bit.
// RQ16: baud mode reloads on overflow silently; trigger sets flag, no reload.
// RQ17: overflows go to the serial port; internal clock is pre-divided by two.
// RQ18: clock output toggles on overflow, started and stopped by run bit.
// RQ19: clock output raises no overflow flag and shares rate with baud.
// RQ20: one interrupt when either flag is set and both enables are set.
// RQ21: software may set flags; only software or reset clears them. In up/down the wrap toggle also clears the event flag.
// RQ22: software stops the timer before touching count or reload bytes.
// RQ23: pins pass two flops; falling edge is a one sample then zero.
//
// Register access over Wishbone was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload_baud
   import timer2_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        count_pin_i,
   output logic             count_pin_o,
   output logic             count_pin_oe_n_o,
   output logic             count_pullup_o,
   input  wire logic        trigger_pin_i,
   output logic             overflow_tick_o,
   output logic             rx_baud_select_o,
   output logic             tx_baud_select_o,
   output logic             timer_irq_o
);

   timer2_state_s st;
   timer2_state_s next_st;

   // word index match on an aligned byte address
   function automatic logic hit(input logic [11:0] adr,
                                input logic [9:0]  idx);
      hit = (adr[11:2] == idx) && (adr[1:0] == 2'b00);
   endfunction

   // up/down set-up: event flag is a wrap bit here, never an event
   function automatic logic updown_cfg(input timer2_state_s s);
      updown_cfg = s.mode[BIT_UPDOWN_EN] && !s.control[BIT_CAPTURE] &&
                   !s.control[BIT_RX_BAUD] && !s.control[BIT_TX_BAUD] &&
                   !(s.mode[BIT_CLK_OUT_EN] && !s.control[BIT_COUNT_SRC]);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decoded controls

   logic        req;
   logic        wr;
   logic        run_bit;
   logic        trigger_enable;
   logic        count_source_select;
   logic        capture_reload_select;
   logic        clock_output_enable;
   logic        updown_enable;
   logic        baud_any;
   logic        clk_out;
   logic        cnt_fall;
   logic        trg_fall;
   logic        trg_level;
   logic        tick;
   logic        count_up;
   logic        ovf_evt;
   logic        down_hit;
   logic        trig_evt;
   logic        tf_set;
   logic        exf_set;
   logic        exf_tgl;
   logic        ctrl_wr;
   logic        cnt_wr_any;
   logic        rld_wr_any;
   timer_mode_e mode_sel;

   // request is taken once; ack drops it out on the following cycle
   assign req = wb_cyc_i && wb_stb_i && !st.ack;
   assign wr  = req && wb_we_i && wb_sel_i[0];

   assign run_bit               = st.control[BIT_RUN];
   assign trigger_enable        = st.control[BIT_TRIG_EN];
   assign count_source_select   = st.control[BIT_COUNT_SRC];
   assign capture_reload_select = st.control[BIT_CAPTURE];
   assign clock_output_enable   = st.mode[BIT_CLK_OUT_EN];
   assign updown_enable         = st.mode[BIT_UPDOWN_EN];
   assign baud_any = st.control[BIT_RX_BAUD] | st.control[BIT_TX_BAUD];
   assign clk_out  = clock_output_enable && !count_source_select;

   // edges only from the second sync flop and its delayed copy
   assign cnt_fall  = st.cnt_prev && !st.cnt_sync[1]; // RQ23
   assign trg_fall  = st.trg_prev && !st.trg_sync[1]; // RQ23
   assign trg_level = st.trg_sync[1];

   // baud or clock output forces the generator whatever bit 0 says
   always_comb begin
      if (!run_bit) begin
         mode_sel = MODE_STOP; // RQ5
      end else if (baud_any || clk_out) begin
         mode_sel = MODE_GENERATE; // RQ10 RQ19
      end else if (capture_reload_select) begin
         mode_sel = MODE_CAPTURE; // RQ7
      end else if (updown_enable) begin
         mode_sel = MODE_UPDOWN; // RQ9
      end else begin
         mode_sel = MODE_RELOAD;
      end
   end

   // pin counting is ignored while the pin is driven, to avoid a loop
   assign tick = run_bit &&
                 ((count_source_select && !clock_output_enable) ?
                  cnt_fall : st.prescale); // RQ5 RQ6 RQ17
   assign count_up = !(mode_sel == MODE_UPDOWN) || trg_level; // RQ13 RQ14
   assign ovf_evt  = tick && count_up && (st.count == COUNT_MAX);
   assign down_hit = tick && !count_up && (st.count == st.reload);
   assign trig_evt = trg_fall && trigger_enable; // RQ2

   assign ctrl_wr    = wr && hit(wb_adr_i, IDX_CONTROL);
   assign cnt_wr_any = wr && (hit(wb_adr_i, IDX_COUNT_LO) ||
                              hit(wb_adr_i, IDX_COUNT_HI));
   assign rld_wr_any = wr && (hit(wb_adr_i, IDX_RELOAD_LO) ||
                              hit(wb_adr_i, IDX_RELOAD_HI));

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;
      tf_set  = 1'b0;
      exf_set = 1'b0;
      exf_tgl = 1'b0;

      // two flops per pin, then one more for the edge compare
      next_st.cnt_sync = {st.cnt_sync[0], count_pin_i}; // RQ23
      next_st.cnt_prev = st.cnt_sync[1];
      next_st.trg_sync = {st.trg_sync[0], trigger_pin_i}; // RQ23
      next_st.trg_prev = st.trg_sync[1];

      // internal clocking counts every second system clock
      next_st.prescale = ~st.prescale; // RQ17

      // counter behaviour per mode
      case (mode_sel)
         MODE_GENERATE: begin
            if (ovf_evt) begin
               next_st.count = st.reload; // RQ16
            end else if (tick) begin
               next_st.count = st.count + COUNT_STEP;
            end
            exf_set = trig_evt; // RQ16 RQ4
         end
         MODE_CAPTURE: begin
            if (tick) begin
               next_st.count = st.count + COUNT_STEP;
            end
            tf_set = ovf_evt; // RQ11
            if (trig_evt) begin
               next_st.reload = st.count; // RQ11 RQ4
            end
            exf_set = trig_evt; // RQ11
         end
         MODE_RELOAD: begin
            if (ovf_evt || trig_evt) begin
               next_st.count = st.reload; // RQ12 RQ4
            end else if (tick) begin
               next_st.count = st.count + COUNT_STEP;
            end
            tf_set  = ovf_evt; // RQ12 RQ1
            exf_set = trig_evt; // RQ12
         end
         MODE_UPDOWN: begin
            // trigger enable has no say here; the pin sets direction
            if (ovf_evt) begin
               next_st.count = st.reload; // RQ13
            end else if (down_hit) begin
               next_st.count = COUNT_MAX; // RQ14
            end else if (tick && count_up) begin
               next_st.count = st.count + COUNT_STEP;
            end else if (tick) begin
               next_st.count = st.count - COUNT_STEP;
            end
            tf_set  = ovf_evt || down_hit; // RQ13 RQ14
            exf_tgl = ovf_evt || down_hit; // RQ15
         end
         MODE_STOP: begin
            // counter not clocked; enabled trigger still reloads or captures unless a baud bit is set, and flags unless up/down
            if (!capture_reload_select && !baud_any && trig_evt) begin
               next_st.count = st.reload; // RQ4
            end else if (capture_reload_select && !baud_any && trig_evt) begin
               next_st.reload = st.count; // RQ4
            end
            exf_set = trig_evt && !updown_cfg(st); // RQ15
         end
         default: begin
            next_st.count = st.count;
         end
      endcase

      // clock output pin toggles on every generator overflow while mode bit 1 is set
      if (ovf_evt && (mode_sel == MODE_GENERATE) && clock_output_enable) begin
         next_st.clk_toggle = ~st.clk_toggle; // RQ18
      end
      next_st.overflow_pulse = ovf_evt && (mode_sel == MODE_GENERATE); // RQ17

      // software writes; data writes win over counting in the same cycle
      if (ctrl_wr) begin
         next_st.control = wb_dat_i[7:0]; // RQ21
      end
      if (wr && hit(wb_adr_i, IDX_MODE)) begin
         next_st.mode = wb_dat_i[1:0];
      end
      if (wr && hit(wb_adr_i, IDX_IRQ_ENABLE)) begin
         next_st.irq_en = wb_dat_i[1:0];
      end
      // hazard: a write that meets a reload corrupts the rate; see RQ22
      if (wr && hit(wb_adr_i, IDX_RELOAD_LO)) begin
         next_st.reload[7:0] = wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, IDX_RELOAD_HI)) begin
         next_st.reload[15:8] = wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, IDX_COUNT_LO)) begin
         next_st.count[7:0] = wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, IDX_COUNT_HI)) begin
         next_st.count[15:8] = wb_dat_i[7:0];
      end

      // hardware set beats a software clear in the same cycle
      next_st.control[BIT_OVERFLOW] = next_st.control[BIT_OVERFLOW]
                                      | tf_set; // RQ1 RQ21
      next_st.control[BIT_EXT_EVENT] = (next_st.control[BIT_EXT_EVENT]
                                        ^ exf_tgl) | exf_set; // RQ2 RQ15

      // one request for both flags; the up/down wrap bit raises none
      next_st.irq = next_st.irq_en[BIT_GLOBAL_IE] && // RQ20
                    next_st.irq_en[BIT_TIMER_IE] &&
                    (next_st.control[BIT_OVERFLOW] |
                     (next_st.control[BIT_EXT_EVENT] &&
                      !updown_cfg(next_st))); // RQ15

      // bus answer: one wait state, unmapped reads give zero
      next_st.ack = req;
      if (req && !wb_we_i) begin
         if (hit(wb_adr_i, IDX_CONTROL)) begin
            next_st.rdata = st.control;
         end else if (hit(wb_adr_i, IDX_MODE)) begin
            next_st.rdata = {6'h00, st.mode};
         end else if (hit(wb_adr_i, IDX_RELOAD_LO)) begin
            next_st.rdata = st.reload[7:0];
         end else if (hit(wb_adr_i, IDX_RELOAD_HI)) begin
            next_st.rdata = st.reload[15:8];
         end else if (hit(wb_adr_i, IDX_COUNT_LO)) begin
            next_st.rdata = st.count[7:0];
         end else if (hit(wb_adr_i, IDX_COUNT_HI)) begin
            next_st.rdata = st.count[15:8];
         end else if (hit(wb_adr_i, IDX_IRQ_ENABLE)) begin
            next_st.rdata = {6'h00, st.irq_en};
         end else begin
            next_st.rdata = RESET_BYTE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign wb_dat_o         = {24'h000000, st.rdata};
   assign wb_ack_o         = st.ack;
   assign count_pin_o      = st.clk_toggle; // RQ18
   assign count_pin_oe_n_o = !clock_output_enable; // RQ8
   assign count_pullup_o   = count_source_select; // RQ6
   assign overflow_tick_o  = st.overflow_pulse; // RQ17
   assign rx_baud_select_o = st.control[BIT_RX_BAUD]; // RQ3
   assign tx_baud_select_o = st.control[BIT_TX_BAUD]; // RQ3
   assign timer_irq_o      = st.irq;

   ////////////////////////////////////////////////////////////////////
   // checks

   a_tf_on_overflow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ovf_evt && mode_sel != MODE_GENERATE) |=> st.control[BIT_OVERFLOW]) // RQ1
      else $error("overflow flag missed on overflow");

   a_tf_baud_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ovf_evt && mode_sel == MODE_GENERATE && !ctrl_wr &&
       !st.control[BIT_OVERFLOW]) |=> !st.control[BIT_OVERFLOW]) // RQ16
      else $error("overflow flag set in generator mode");

   a_exf_trigger: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (trig_evt && mode_sel != MODE_UPDOWN && !updown_enable)
      |=> st.control[BIT_EXT_EVENT]) // RQ2
      else $error("event flag missed on trigger edge");

   a_run_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!run_bit && !trig_evt && !cnt_wr_any) |=> $stable(st.count)) // RQ5
      else $error("counter moved while stopped");

   a_reload_up: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ovf_evt && mode_sel != MODE_CAPTURE && !cnt_wr_any && !rld_wr_any)
      |=> st.count == $past(st.reload)) // RQ12
      else $error("no reload after overflow");

   a_down_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (down_hit && mode_sel == MODE_UPDOWN && !cnt_wr_any)
      |=> st.count == COUNT_MAX) // RQ14
      else $error("down wrap did not load all ones");

   a_exf_toggle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (mode_sel == MODE_UPDOWN && (ovf_evt || down_hit) && !ctrl_wr)
      |=> st.control[BIT_EXT_EVENT] != $past(st.control[BIT_EXT_EVENT])) // RQ15
      else $error("event flag did not toggle on wrap");

   a_capture_copy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (trig_evt && mode_sel == MODE_CAPTURE && !rld_wr_any)
      |=> st.reload == $past(st.count)) // RQ11
      else $error("capture register not loaded");

   a_clkout_toggle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (ovf_evt && clk_out) |=> count_pin_o != $past(count_pin_o)) // RQ18
      else $error("clock output did not toggle");

   a_irq_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (tf_set && &st.irq_en) |=> timer_irq_o) // RQ20
      else $error("interrupt missing after flag set");

   a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle");

endmodule // timer2_capture_reload_baud

`default_nettype wire

//--- timer2_pkg.sv
// constants, register map and state carrier for the timer 2 block
// assumes a classic wishbone master with 32-bit data, registers in bits 7:0
package timer2_pkg;

   // register word indices; byte address is four times the index
   localparam logic [9:0] IDX_CONTROL    = 10'h0c8;
   localparam logic [9:0] IDX_MODE       = 10'h0c9;
   localparam logic [9:0] IDX_RELOAD_LO  = 10'h0ca;
   localparam logic [9:0] IDX_RELOAD_HI  = 10'h0cb;
   localparam logic [9:0] IDX_COUNT_LO   = 10'h0cc;
   localparam logic [9:0] IDX_COUNT_HI   = 10'h0cd;
   localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0d0;

   // control register bit positions
   localparam int BIT_OVERFLOW   = 7;
   localparam int BIT_EXT_EVENT  = 6;
   localparam int BIT_RX_BAUD    = 5;
   localparam int BIT_TX_BAUD    = 4;
   localparam int BIT_TRIG_EN    = 3;
   localparam int BIT_RUN        = 2;
   localparam int BIT_COUNT_SRC  = 1;
   localparam int BIT_CAPTURE    = 0;

   // mode register bit positions
   localparam int BIT_CLK_OUT_EN = 1;
   localparam int BIT_UPDOWN_EN  = 0;

   // interrupt enable register bit positions
   localparam int BIT_GLOBAL_IE  = 1;
   localparam int BIT_TIMER_IE   = 0;

   // widths, reset values and count limits
   localparam int          BYTE_W       = 8;
   localparam int          BUS_W        = 32;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [15:0] RESET_WORD   = 16'h0000;
   localparam logic [15:0] COUNT_MAX    = 16'hffff;
   localparam logic [15:0] COUNT_STEP   = 16'h0001;
   localparam real         CLK_PERIOD_NS = 10.0;

   // decoded operating mode
   typedef enum logic [2:0] {
      MODE_STOP,
      MODE_CAPTURE,
      MODE_RELOAD,
      MODE_UPDOWN,
      MODE_GENERATE
   } timer_mode_e;

   // every flip-flop of the block
   typedef struct packed {
      logic [1:0]  cnt_sync;
      logic        cnt_prev;
      logic [1:0]  trg_sync;
      logic        trg_prev;
      logic        prescale;
      logic [15:0] count;
      logic [15:0] reload;
      logic [7:0]  control;
      logic [1:0]  mode;
      logic [1:0]  irq_en;
      logic        clk_toggle;
      logic        overflow_pulse;
      logic        ack;
      logic [7:0]  rdata;
      logic        irq;
   } timer2_state_s;

   localparam timer2_state_s STATE_RESET = '0;

endpackage
